// ---- ues_regs.vh ----
// register offsets, field positions and timing figures for the usb event status block
`ifndef UES_REGS_VH
`define UES_REGS_VH
// register indices on the plain register port
`define UES_ADDR_STATUS 4'h0
`define UES_ADDR_INTEN 4'h1
`define UES_ADDR_EVEN 4'h2
`define UES_ADDR_EPREADY 4'h3
// status fields
`define UES_B_PWRCHG 15
`define UES_B_WAKE 14
`define UES_B_FRAME 13
`define UES_B_STCHG 12
`define UES_B_CTLCHG 11
`define UES_B_EMPTY 10
`define UES_B_NRDY 9
`define UES_B_RDY 8
`define UES_B_PWRLVL 7
`define UES_B_SETUP 3
// event enable register fields
`define UES_E_BUSRST 0
`define UES_E_ADDR 1
`define UES_E_CFG 2
`define UES_E_DOZE 3
`define UES_E_WRST 4
`define UES_E_READ_STATUS_ENTRY_ENABLE 5
`define UES_E_FIN 6
`define UES_E_FAULT 7
`define UES_E_SETUP 8
// device states
`define UES_ST_POWERED 3'h0
`define UES_ST_DEFAULT 3'h1
`define UES_ST_ADDRESS 3'h2
`define UES_ST_CONFIG 3'h3
`define UES_ST_SUSPEND 3'h4
// control stages
`define UES_CS_IDLE 3'h0
`define UES_CS_RDDATA 3'h1
`define UES_CS_RDSTAT 3'h2
`define UES_CS_WRDATA 3'h3
`define UES_CS_WRSTAT 3'h4
`define UES_CS_NDSTAT 3'h5
`define UES_CS_SEQERR 3'h6
// stall response code
`define UES_PID_STALL 2'h2
// timing: bus reset in ns, suspend idle in us
`define UES_RESET_NS 2500
`define UES_IDLE_US 3000
`define UES_CLK_MHZ 20
`endif

// ---- ues_event_status.v ----
// usb device event status register with device state and control stage tracking
// Overview of operation
// - bit 7 shows bus power pin level through a two-stage synchroniser; needs clock.
// - bits 6..4 show device state; 1xx means suspended; writes ignored.
// - bit 3 set on setup packet; write 0 clears, write 1 nothing.
// - bits 2..0 show control stage; 110 is sequence error; read only.
// - bits 15..8 are flags; interrupt when flag set and enabled.
// - bit 15 set on each bus power edge; write 0 clears.
// - power and wake flags need the running clock; software writes 0 then 1.
// - bit 14 set on J to K or J to SE0 while suspended.
// - bit 13 set when frame start arrives and frame number latched.
// - SE0 for 2.5 us is bus reset; go default, flag change.
// - nonzero set-address in default goes address after status; address stored.
// - set-configuration state change flagged after host acks status packet.
// - idle 3 ms suspends from any active state and flags change.
// - bit 12 only for transitions whose own enable is on.
// - bit 11 set on enabled control stage events.
// - bit 10 follows OR of endpoint empty/overflow bits.
// - bit 9 follows OR of endpoint not-ready bits.
// - bit 8 follows OR of endpoint ready bits.
// - writing 1 to any clearable flag leaves it unchanged.
// - sequence error forces endpoint zero response to stall.
`timescale 1ns/10ps
`include "ues_regs.vh"
module ues_event_status #(
  parameter NUM_EP = 7,
  parameter RESET_CYCLES = (`UES_RESET_NS * `UES_CLK_MHZ + 999) / 1000,
  parameter IDLE_CYCLES = `UES_IDLE_US * `UES_CLK_MHZ
)(
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // register port
  input wire [3:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [15:0] regRdData,
  // bus side pins, asynchronous
  input wire busPower,
  input wire linePlus,
  input wire lineMinus,
  // protocol events from the serial engine, one-cycle pulses
  input wire setupRcvd,
  input wire setupAckSent,
  input wire setupIsRead,
  input wire setupNoData,
  input wire setAddrReq,
  input wire [6:0] setAddrValue,
  input wire setCfgReq,
  input wire [7:0] setCfgValue,
  input wire statusZlpSent,
  input wire statusZlpAcked,
  input wire dataInToken,
  input wire dataOutToken,
  input wire dataXferDone,
  input wire seqFaultDetect,
  input wire frameLatched,
  // endpoint summaries
  input wire [NUM_EP-1:0] endpointEmptyOverflowBits,
  input wire [NUM_EP-1:0] endpointNotReadyBits,
  input wire [NUM_EP-1:0] endpointReadyBits,
  // outputs
  output reg irqOut,
  output reg [6:0] deviceAddr,
  output reg [1:0] epZeroResponseField,
  output reg epZeroForce
);
  // flag and state registers
  reg [7:0] flags_q;
  reg setupSeen_q;
  reg [2:0] devState_q;
  reg [2:0] resumeState_q;
  reg [2:0] ctrlStage_q;
  reg [7:0] intEnable_q;
  reg [8:0] eventEnable_q;
  reg [1:0] pendMove_q;
  reg [6:0] addrLatch_q;
  // synchronisers
  reg pwrMeta_q, pwrSync_q, pwrPrev_q;
  reg dpMeta_q, dpSync_q, dmMeta_q, dmSync_q;
  reg lineJPrev_q;
  // fill marker: blocks a false power edge while the chain loads after reset
  reg [2:0] pwrFill_q;
  reg [31:0] se0Count_q;
  reg [31:0] idleCount_q;
  // line conditions: J is D+ high D- low; SE0 both low
  // both syncs reset low, so SE0 shows for two cycles after reset, far below the timer
  wire lineSe0 = ~dpSync_q & ~dmSync_q;
  wire lineJ = dpSync_q & ~dmSync_q;
  wire lineK = ~dpSync_q & dmSync_q;
  wire suspended = devState_q[2];
  wire wrStatus = regWrite && (regAddr == `UES_ADDR_STATUS);
  wire busResetHit = lineSe0 && (se0Count_q == RESET_CYCLES - 1);
  // idle counts only on J, so a K or SE0 held by the host keeps the device awake
  // idle timer
  wire idleHit = lineJ && !suspended && (idleCount_q == IDLE_CYCLES - 1);
  wire pwrEdge = pwrFill_q[2] && (pwrSync_q ^ pwrPrev_q);
  // wake on J to K or J to SE0 while suspended
  wire wakeEvt = suspended && lineJPrev_q && (lineK || lineSe0);
  // address move after status zlp sent
  wire addrMove = statusZlpSent && pendMove_q == 2'h1;
  // configure move after host acks zlp
  wire cfgMove = statusZlpAcked && pendMove_q == 2'h2;
  // state change gated by its own enable
  wire stEvt = (busResetHit && eventEnable_q[`UES_E_BUSRST]) || (addrMove && eventEnable_q[`UES_E_ADDR])
    || (cfgMove && eventEnable_q[`UES_E_CFG]) || (idleHit && eventEnable_q[`UES_E_DOZE]);
  wire wrStEvt = ctrlStage_q == `UES_CS_WRDATA && dataInToken;
  wire rdStEvt = ctrlStage_q == `UES_CS_RDDATA && dataOutToken;
  wire finEvt = dataXferDone && (ctrlStage_q == `UES_CS_WRSTAT || ctrlStage_q == `UES_CS_RDSTAT
    || ctrlStage_q == `UES_CS_NDSTAT);
  wire ctEvt = (setupAckSent && eventEnable_q[`UES_E_SETUP]) || (wrStEvt && eventEnable_q[`UES_E_WRST])
    || (rdStEvt && eventEnable_q[`UES_E_READ_STATUS_ENTRY_ENABLE]) || (finEvt && eventEnable_q[`UES_E_FIN])
    || (seqFaultDetect && eventEnable_q[`UES_E_FAULT]);

  // synchronise asynchronous pins
  // D+ and D- pass their chains in step, so a J to K swap is seen on one edge
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pwrMeta_q <= 1'b0;
      pwrSync_q <= 1'b0;
      pwrPrev_q <= 1'b0;
      dpMeta_q <= 1'b0;
      dpSync_q <= 1'b0;
      dmMeta_q <= 1'b0;
      dmSync_q <= 1'b0;
      lineJPrev_q <= 1'b0;
      pwrFill_q <= 3'h0;
    end
    else
    begin
      pwrMeta_q <= busPower;
      pwrSync_q <= pwrMeta_q;
      pwrPrev_q <= pwrSync_q;
      dpMeta_q <= linePlus;
      dpSync_q <= dpMeta_q;
      dmMeta_q <= lineMinus;
      dmSync_q <= dmMeta_q;
      lineJPrev_q <= lineJ;
      // marker fills one bit per edge; edges count only once prev holds a real level
      pwrFill_q <= {pwrFill_q[1:0], 1'b1};
    end
  end

  // se0 and idle timers
  // each counter restarts after a hit, so a long SE0 repeats the bus reset
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      se0Count_q <= 32'h00000000;
      idleCount_q <= 32'h00000000;
    end
    else
    begin
      se0Count_q <= (lineSe0 && !busResetHit) ? se0Count_q + 32'h00000001 : 32'h00000000;
      idleCount_q <= (lineJ && !suspended && !idleHit) ? idleCount_q + 32'h00000001 : 32'h00000000;
    end
  end

  // device state machine
  // resume on K returns to the state held before suspend; SE0 waits for bus reset
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      devState_q <= `UES_ST_POWERED;
      resumeState_q <= `UES_ST_POWERED;
      pendMove_q <= 2'h0;
      addrLatch_q <= 7'h00;
    end
    else
    begin
      if (setAddrReq)
        addrLatch_q <= setAddrValue;
      if (setAddrReq && devState_q == `UES_ST_DEFAULT && setAddrValue != 7'h00)
        pendMove_q <= 2'h1;
      else if (setCfgReq && ((devState_q == `UES_ST_ADDRESS && setCfgValue != 8'h00)
        || (devState_q == `UES_ST_CONFIG && setCfgValue == 8'h00)))
        pendMove_q <= 2'h2;
      else if (addrMove || cfgMove || setupRcvd)
        pendMove_q <= 2'h0;
      // bus reset wins from any state
      if (busResetHit)
      begin
        devState_q <= `UES_ST_DEFAULT;
        pendMove_q <= 2'h0;
      end
      else if (idleHit)
      begin
        resumeState_q <= devState_q;
        devState_q <= `UES_ST_SUSPEND;
      end
      else if (wakeEvt && lineK)
        devState_q <= resumeState_q;
      else
      begin
        case (devState_q)
          `UES_ST_DEFAULT:
            if (addrMove)
              devState_q <= `UES_ST_ADDRESS;
          `UES_ST_ADDRESS:
            if (cfgMove)
              devState_q <= `UES_ST_CONFIG;
          `UES_ST_CONFIG:
            if (cfgMove)
              devState_q <= `UES_ST_ADDRESS;
          default:
            devState_q <= devState_q;
        endcase
      end
    end
  end

  // control stage machine
  // a new setup packet always restarts the tracker, even from a sequence error
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrlStage_q <= `UES_CS_IDLE;
    else if (setupRcvd)
      ctrlStage_q <= `UES_CS_IDLE;
    else if (seqFaultDetect)
      ctrlStage_q <= `UES_CS_SEQERR;
    else
    begin
      case (ctrlStage_q)
        `UES_CS_IDLE:
          if (setupAckSent)
            ctrlStage_q <= setupNoData ? `UES_CS_NDSTAT : (setupIsRead ? `UES_CS_RDDATA : `UES_CS_WRDATA);
        `UES_CS_RDDATA:
          if (dataOutToken)
            ctrlStage_q <= `UES_CS_RDSTAT;
        `UES_CS_WRDATA:
          if (dataInToken)
            ctrlStage_q <= `UES_CS_WRSTAT;
        `UES_CS_RDSTAT, `UES_CS_WRSTAT, `UES_CS_NDSTAT:
          if (dataXferDone)
            ctrlStage_q <= `UES_CS_IDLE;
        default:
          ctrlStage_q <= ctrlStage_q;
      endcase
    end
  end

  // flags: set wins over a same-cycle clear by write of 0
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flags_q <= 8'h00;
      setupSeen_q <= 1'b0;
    end
    else
    begin
      // zero then one writes
      // with the clock running the trailing write of 1 simply leaves the flag clear;
      // clock-stopped operation of the power and wake flags is not modelled here
      // write 1 keeps flag, write 0 clears
      if (wrStatus)
      begin
        flags_q[7:3] <= flags_q[7:3] & regWrData[`UES_B_PWRCHG:`UES_B_CTLCHG];
        setupSeen_q <= setupSeen_q & regWrData[`UES_B_SETUP];
      end
      if (pwrEdge)
        flags_q[7] <= 1'b1;
      if (wakeEvt)
        flags_q[6] <= 1'b1;
      if (frameLatched)
        flags_q[5] <= 1'b1;
      if (stEvt)
        flags_q[4] <= 1'b1;
      if (ctEvt)
        flags_q[3] <= 1'b1;
      if (setupRcvd)
        setupSeen_q <= 1'b1;
      // summaries are plain ORs, one cycle behind the endpoint inputs
      // empty overflow summary
      flags_q[2] <= |endpointEmptyOverflowBits;
      flags_q[1] <= |endpointNotReadyBits;
      flags_q[0] <= |endpointReadyBits;
    end
  end

  // enable registers
  // event enables gate only the flags, never the state or stage tracking
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      intEnable_q <= 8'h00;
      eventEnable_q <= 9'h000;
    end
    else if (regWrite && regAddr == `UES_ADDR_INTEN)
      intEnable_q <= regWrData[7:0];
    else if (regWrite && regAddr == `UES_ADDR_EVEN)
      eventEnable_q <= regWrData[8:0];
  end

  // interrupt is the level of any enabled flag, one cycle late
  // it stays high until the flag clears (software write, or summary inputs dropping) or its enable clears
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqOut <= 1'b0;
    end
    else
    begin
      irqOut <= |(flags_q & intEnable_q);
    end
  end

  // endpoint zero response and address outputs
  // the stall code lasts one cycle; the endpoint logic must latch it
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      epZeroResponseField <= 2'h0;
      epZeroForce <= 1'b0;
      deviceAddr <= 7'h00;
    end
    else
    begin
      epZeroForce <= seqFaultDetect;
      epZeroResponseField <= seqFaultDetect ? `UES_PID_STALL : 2'h0;
      deviceAddr <= addrLatch_q;
    end
  end

  // read data, one cycle after strobe
  // any cycle without a read strobe returns zero
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      regRdData <= 16'h0000;
    else if (regRead)
    begin
      case (regAddr)
        `UES_ADDR_STATUS:
          regRdData <= {flags_q, pwrSync_q, devState_q, setupSeen_q, ctrlStage_q};
        `UES_ADDR_INTEN:
          regRdData <= {8'h00, intEnable_q};
        `UES_ADDR_EVEN:
          regRdData <= {7'h00, eventEnable_q};
        `UES_ADDR_EPREADY:
          regRdData <= {9'h000, deviceAddr};
        default:
          regRdData <= 16'h0000;
      endcase
    end
    else
      regRdData <= 16'h0000;
  end
endmodule

// ---- ues_event_status_checker.sv ----
// assertion checker for the usb event status block, bound to its top module
`timescale 1ns/10ps
module ues_event_status_checker #(
  parameter NUM_EP = 7
)(
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // register port
  input wire [3:0] regAddr,
  input wire regRead,
  input wire [15:0] regRdData,
  // pins and events
  input wire busPower,
  input wire setAddrReq,
  input wire [6:0] setAddrValue,
  input wire seqFaultDetect,
  input wire [NUM_EP-1:0] endpointEmptyOverflowBits,
  input wire [NUM_EP-1:0] endpointNotReadyBits,
  input wire [NUM_EP-1:0] endpointReadyBits,
  // outputs
  input wire irqOut,
  input wire [6:0] deviceAddr,
  input wire [1:0] epZeroResponseField,
  input wire epZeroForce
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // status register read request
  sequence s_stat_rd;
    regRead && regAddr == 4'h0;
  endsequence
  // supply steady high for four cycles, with a status read in the last of them
  sequence s_pwr_high;
    busPower [*4] ##0 s_stat_rd;
  endsequence
  // fault pulse, then a status read two cycles on
  sequence s_fault_rd;
    seqFaultDetect ##2 s_stat_rd;
  endsequence
  property p_lvl; s_pwr_high |=> regRdData[7]; endproperty
  property p_stage; s_fault_rd |=> regRdData[2:0] == 3'h6; endproperty
  property p_stall; seqFaultDetect |=> epZeroResponseField == 2'h2 && epZeroForce; endproperty
  property p_addr; setAddrReq |=> ##1 deviceAddr == $past(setAddrValue, 2); endproperty
  property p_rst; $rose(reset_n) |-> !irqOut && deviceAddr == 7'h00 && !epZeroForce; endproperty
  property p_empty; s_stat_rd |=> regRdData[10] == $past(|endpointEmptyOverflowBits, 2); endproperty
  property p_nrdy; s_stat_rd |=> regRdData[9] == $past(|endpointNotReadyBits, 2); endproperty
  property p_rdy; s_stat_rd |=> regRdData[8] == $past(|endpointReadyBits, 2); endproperty
  a_lvl: assert property (p_lvl) else $error("power level bit low");
  a_stage: assert property (p_stage) else $error("stage not fault code");
  a_stall: assert property (p_stall) else $error("no stall after fault");
  a_addr: assert property (p_addr) else $error("address not stored");
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  a_empty: assert property (p_empty) else $error("empty summary wrong");
  a_nrdy: assert property (p_nrdy) else $error("not ready summary wrong");
  a_rdy: assert property (p_rdy) else $error("ready summary wrong");
endmodule
bind ues_event_status ues_event_status_checker #(.NUM_EP(NUM_EP)) ues_event_status_checker_inst (.sys_clk, .reset_n,
  .regAddr, .regRead, .regRdData, .busPower, .setAddrReq, .setAddrValue, .seqFaultDetect, .endpointEmptyOverflowBits,
  .endpointNotReadyBits, .endpointReadyBits, .irqOut, .deviceAddr, .epZeroResponseField, .epZeroForce);

// ---- ues_host_model.sv ----
// behavioural host: drives bus supply and the data line pair
`timescale 1ns/10ps
module ues_host_model (
  // commands from the bench
  input wire [1:0] lineMode,
  input wire powerOn,
  // bus pins
  output wire busPower,
  output wire linePlus,
  output wire lineMinus
);
  assign busPower = powerOn;
  // line states: 0 idle J, 1 SE0, 2 K
  assign linePlus = (lineMode == 2'h0);
  assign lineMinus = (lineMode == 2'h2);
endmodule

// ---- ues_event_status_tb_top.sv ----
// self-checking bench for the usb event status block
`timescale 1ns/10ps
module ues_event_status_tb_top;
  // stimulus and observed signals
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [1:0] lineMode = 2'h2;
  logic powerOn = 1'b1;
  logic [12:0] ev = 13'h0000;
  logic [7:0] val = 8'h00;
  logic [6:0] epE = 7'h00;
  logic [6:0] epN = 7'h00;
  logic [6:0] epR = 7'h00;
  logic [15:0] d;
  wire [15:0] regRdData;
  wire busPower, linePlus, lineMinus, irqOut;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  // 50 ns clock
  always #25 sys_clk = ~sys_clk;
  ues_host_model ues_host_model_inst (.lineMode, .powerOn, .busPower, .linePlus, .lineMinus);
  ues_event_status #(.RESET_CYCLES(4), .IDLE_CYCLES(20)) ues_event_status_inst (
    .sys_clk, .reset_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .busPower, .linePlus, .lineMinus,
    .setupRcvd(ev[3]), .setupAckSent(ev[5]), .setupIsRead(ev[11]), .setupNoData(ev[12]), .setAddrReq(ev[0]),
    .setAddrValue(val[6:0]), .setCfgReq(ev[6]), .setCfgValue(val), .statusZlpSent(ev[1]), .statusZlpAcked(ev[7]),
    .dataInToken(ev[8]), .dataOutToken(ev[9]), .dataXferDone(ev[10]), .seqFaultDetect(ev[2]), .frameLatched(ev[4]),
    .endpointEmptyOverflowBits(epE), .endpointNotReadyBits(epN), .endpointReadyBits(epR), .irqOut,
    .deviceAddr(), .epZeroResponseField(), .epZeroForce());
  // compare and count
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error at %0t ns: got %h, expected %h", $time, s, e);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  // one-cycle register read; data stand in the next cycle and are taken at its closing edge
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(posedge sys_clk);
    d = regRdData;
  endtask
  // one-cycle event pattern, for qualifiers that must stand beside their strobe
  task automatic pulse_m(input logic [12:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= 13'h0000;
  endtask
  // one-cycle protocol event
  task automatic pulse(input int i);
    @(posedge sys_clk);
    ev[i] <= 1'b1;
    @(posedge sys_clk);
    ev <= 13'h0000;
  endtask
  // reset values
  task automatic t_reset;
    rd(4'h0);
    chk(d, 16'h0080);
    rd(4'h3);
    chk(d, 16'h0000);
  endtask
  // bus reset, addressing and configuration
  task automatic t_enum;
    wr(4'h1, 16'h00FF);
    wr(4'h2, 16'h01FF);
    lineMode <= 2'h1;
    repeat (10) @(posedge sys_clk);
    lineMode <= 2'h2;
    rd(4'h0);
    chk(d & 16'h1070, 16'h1010);
    chk({15'h0000, irqOut}, 16'h0001);
    wr(4'h0, 16'hEFFF);
    rd(4'h0);
    chk(d & 16'h1070, 16'h0010);
    val <= 8'h05;
    pulse(0);
    pulse(1);
    rd(4'h0);
    chk(d & 16'h0070, 16'h0020);
    rd(4'h3);
    chk(d, 16'h0005);
    val <= 8'h01;
    pulse(6);
    pulse(1);
    pulse(7);
    rd(4'h0);
    chk(d & 16'h1070, 16'h1030);
  endtask
  // setup flag and sequence fault
  task automatic t_fault;
    pulse(3);
    rd(4'h0);
    chk(d & 16'h0008, 16'h0008);
    wr(4'h0, 16'hFFF7);
    pulse(2);
    rd(4'h0);
    chk(d & 16'h080F, 16'h0806);
  endtask
  // control read, write and no-data sequences walk the stage field
  task automatic t_ctl;
    pulse(3);
    wr(4'h0, 16'hF7FF);
    pulse_m(13'h0820);
    rd(4'h0);
    chk(d & 16'h0807, 16'h0801);
    wr(4'h0, 16'hF7FF);
    pulse(9);
    rd(4'h0);
    chk(d & 16'h0807, 16'h0802);
    wr(4'h0, 16'hF7FF);
    pulse(10);
    rd(4'h0);
    chk(d & 16'h0807, 16'h0800);
    wr(4'h2, 16'h00FF);
    wr(4'h0, 16'hF7FF);
    pulse_m(13'h0020);
    rd(4'h0);
    chk(d & 16'h0807, 16'h0003);
    pulse(8);
    rd(4'h0);
    chk(d & 16'h0807, 16'h0804);
    pulse(10);
    pulse_m(13'h1020);
    rd(4'h0);
    chk(d & 16'h0007, 16'h0005);
  endtask
  // endpoint summaries are read only
  task automatic t_sum;
    epR <= 7'h01;
    epN <= 7'h02;
    epE <= 7'h04;
    rd(4'h0);
    chk(d & 16'h0700, 16'h0700);
    wr(4'h0, 16'h0000);
    rd(4'h0);
    chk(d & 16'h0700, 16'h0700);
    epR <= 7'h00;
    epN <= 7'h00;
    epE <= 7'h00;
    wr(4'h0, 16'h0000);
    rd(4'h0);
    chk(d & 16'hFF00, 16'h0000);
    chk({15'h0000, irqOut}, 16'h0000);
  endtask
  // supply edge and frame start
  task automatic t_pwr;
    powerOn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(4'h0);
    chk(d & 16'h8080, 16'h8000);
    wr(4'h0, 16'h7FFF);
    wr(4'h0, 16'hFFFF);
    rd(4'h0);
    chk(d & 16'h8000, 16'h0000);
    pulse(4);
    rd(4'h0);
    chk(d & 16'h2000, 16'h2000);
  endtask
  // idle bus suspends, K resumes
  task automatic t_doze;
    lineMode <= 2'h0;
    repeat (30) @(posedge sys_clk);
    rd(4'h0);
    chk(d & 16'h0040, 16'h0040);
    lineMode <= 2'h2;
    repeat (4) @(posedge sys_clk);
    rd(4'h0);
    chk(d & 16'h4000, 16'h4000);
  endtask
  // verdict and end of run
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // cycle ceiling against hangs
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  // main sequence
  initial
  begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_enum();
    t_fault();
    t_ctl();
    t_sum();
    t_pwr();
    t_doze();
    end_of_test();
  end
endmodule
